// file: design/drs_supervisor.sv
`timescale 1ns/1ps
module drs_supervisor #(
  parameter int unsigned RELEASE_CYC = drs_pkg::RELEASE_DELAY_CYC
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input drs_pkg::drs_supply_type supply,
  input drs_pkg::drs_fault_type fault,
  input wire logic core_in_switch_on,
  input wire logic regulator_tick,
  input wire logic watchdog_ok,
  input wire logic watchdog_fail,
  output logic primary_reset_n,
  output logic supervised_reset_n,
  output logic core_shutdown_req
);
  logic [drs_pkg::SYNC_STAGES-1:0] rst_sync;
  logic srst_n;
  logic core_volt_bad;
  logic core_volt_fault;
  logic [9:0] glitch_count;
  logic reserve_ok;
  logic [23:0] delay_count;
  logic wd_seen;
  logic [2:0] chk_ticks;
  logic oc_latched;
  logic fault_now;
  logic supplies_good;
  drs_pkg::drs_state_type state;
  drs_pkg::drs_state_type next_state;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync <= '0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign srst_n = rst_sync[1];

  // ---------------------------------------------------------------
  // Core supply persistence
  // ---------------------------------------------------------------
  assign core_volt_bad = fault.core_ov || fault.core_uv;

  drs_persist_filter #(
    .LIMIT(drs_pkg::CORE_FAULT_CYCLES),
    .CW(4)
  ) u_core_filter (
    .core_clk(core_clk),
    .rst_n(srst_n),
    .level_in(core_volt_bad),
    .tick(regulator_tick),
    .level_out(core_volt_fault)
  );

  // Independent tick count for the persistence check
  always_ff @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
      chk_ticks <= '0;
    else if (!core_volt_bad)
      chk_ticks <= '0;
    else if (regulator_tick && chk_ticks != 3'h7)
      chk_ticks <= chk_ticks + 1'b1;
  end

  // ---------------------------------------------------------------
  // Reserve supply deglitch
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      glitch_count <= '0;
      reserve_ok <= 1'b0;
    end
    else if (supply.reserve_good)
    begin
      glitch_count <= '0;
      reserve_ok <= 1'b1;
    end
    else if (glitch_count < 10'(drs_pkg::GLITCH_CYC))
      glitch_count <= glitch_count + 1'b1;
    else
      reserve_ok <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Overcurrent during switch-on
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
      oc_latched <= 1'b0;
    else
      oc_latched <= fault.core_oc && core_in_switch_on;
  end

  // ---------------------------------------------------------------
  // Fault combination
  // ---------------------------------------------------------------
  assign supplies_good = supply.core_good && supply.peri_good
    && reserve_ok;
  assign fault_now = fault.core_ov || fault.peri_ov
    || core_volt_fault
    || oc_latched
    || !supply.internal_good
    || !supplies_good;

  always_ff @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
      core_shutdown_req <= 1'b0;
    else
      core_shutdown_req <= fault.core_ov;
  end

  // ---------------------------------------------------------------
  // Release sequence
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      drs_pkg::DRS_HOLD:
        if (!fault_now)
          next_state = drs_pkg::DRS_DELAY;
      drs_pkg::DRS_DELAY:
        if (fault_now)
          next_state = drs_pkg::DRS_HOLD;
        else if (delay_count >= 24'(RELEASE_CYC - 1))
          next_state = drs_pkg::DRS_RUN;
      drs_pkg::DRS_RUN:
        if (fault_now || watchdog_fail)
          next_state = drs_pkg::DRS_HOLD;
      default:
        next_state = drs_pkg::DRS_HOLD;
    endcase
  end

  always_ff @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
      state <= drs_pkg::DRS_HOLD;
    else
      state <= next_state;
  end

  always_ff @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
      delay_count <= '0;
    else if (state != drs_pkg::DRS_DELAY || fault_now)
      delay_count <= '0;
    else
      delay_count <= delay_count + 1'b1;
  end

  always_ff @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
      wd_seen <= 1'b0;
    else if (next_state != drs_pkg::DRS_RUN)
      wd_seen <= 1'b0;
    else if (watchdog_ok && !watchdog_fail)
      wd_seen <= 1'b1;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      primary_reset_n <= drs_pkg::RESET_OUT_VALUE;
      supervised_reset_n <= drs_pkg::RESET_OUT_VALUE;
    end
    else
    begin
      primary_reset_n <= (next_state == drs_pkg::DRS_RUN);
      supervised_reset_n <= (next_state == drs_pkg::DRS_RUN)
        && watchdog_ok && !watchdog_fail;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_ov_forces_low: assert property (@(posedge core_clk)
    disable iff (!srst_n)
    (fault.core_ov || fault.peri_ov) |=> !primary_reset_n
      && !supervised_reset_n)
    else $error("overvoltage did not force resets low");

  chk_secondary_and: assert property (@(posedge core_clk)
    disable iff (!srst_n)
    supervised_reset_n |-> primary_reset_n)
    else $error("secondary high while primary low");

  chk_wd_fail_low: assert property (@(posedge core_clk)
    disable iff (!srst_n)
    watchdog_fail |=> !primary_reset_n && !supervised_reset_n)
    else $error("bad trigger did not drop resets");

  chk_internal_low: assert property (@(posedge core_clk)
    disable iff (!srst_n)
    !supply.internal_good |=> !primary_reset_n)
    else $error("internal supply loss did not drop reset");

  chk_release_delay: assert property (@(posedge core_clk)
    disable iff (!srst_n)
    $rose(primary_reset_n) |-> $past(state) == drs_pkg::DRS_DELAY
      && $past(delay_count) == 24'(RELEASE_CYC - 1))
    else $error("primary released without delay");

  chk_shutdown_req: assert property (@(posedge core_clk)
    disable iff (!srst_n)
    fault.core_ov |=> core_shutdown_req)
    else $error("core overvoltage gave no shutdown request");

  chk_oc_low: assert property (@(posedge core_clk)
    disable iff (!srst_n)
    fault.core_oc && core_in_switch_on |=> ##1 !primary_reset_n)
    else $error("overcurrent did not drop reset");

  chk_core_persist: assert property (@(posedge core_clk)
    disable iff (!srst_n)
    core_volt_fault == (core_volt_bad
      && chk_ticks > 3'(drs_pkg::CORE_FAULT_CYCLES)))
    else $error("core fault does not match persistence count");

  chk_first_trigger: assert property (@(posedge core_clk)
    disable iff (!srst_n)
    supervised_reset_n |-> wd_seen)
    else $error("secondary high without a valid trigger");

  chk_wd_ok_high: assert property (@(posedge core_clk)
    disable iff (!srst_n)
    primary_reset_n && !fault_now && watchdog_ok && !watchdog_fail
      |=> supervised_reset_n)
    else $error("good trigger did not raise secondary");

  cov_release: cover property (@(posedge core_clk) $rose(primary_reset_n));
  cov_secondary: cover property (@(posedge core_clk)
    $rose(supervised_reset_n));
  cov_wd_drop: cover property (@(posedge core_clk)
    primary_reset_n ##1 watchdog_fail);

endmodule

// file: include/drs_pkg.sv
package drs_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned RELEASE_DELAY_MS = 16;
  localparam int unsigned RELEASE_DELAY_CYC =
    RELEASE_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned GLITCH_MIN_US = 10;
  localparam int unsigned GLITCH_CYC = GLITCH_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CORE_FAULT_CYCLES = 4;
  localparam int unsigned SYNC_STAGES = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic RESET_OUT_VALUE = 1'b0;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic core_good;
    logic peri_good;
    logic reserve_good;
    logic internal_good;
  } drs_supply_type;

  typedef struct packed {
    logic core_ov;
    logic peri_ov;
    logic core_uv;
    logic core_oc;
  } drs_fault_type;

  typedef enum logic [1:0] {
    DRS_HOLD,
    DRS_DELAY,
    DRS_RUN
  } drs_state_type;

endpackage

// file: design/drs_persist_filter.sv
`timescale 1ns/1ps
module drs_persist_filter #(
  parameter int unsigned LIMIT = 4,
  parameter int unsigned CW = 16
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic level_in,
  input wire logic tick,
  output logic level_out
);
  logic [CW-1:0] count;

  // ---------------------------------------------------------------
  // Count ticks while input asserted
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      count <= '0;
    else if (!level_in)
      count <= '0;
    else if (tick && count <= CW'(LIMIT))
      count <= count + 1'b1;
  end

  assign level_out = level_in && (count > CW'(LIMIT));

endmodule

// file: dv/drs_mcu_model.sv
`timescale 1ns/1ps
module drs_mcu_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic primary_reset_n,
  input wire logic supervised_reset_n,
  input wire logic trig_en,
  output logic watchdog_ok,
  output logic in_reset
);
  // ----------------------------------
  // Reset view and trigger source
  // ----------------------------------
  logic [1:0] cnt;
  assign in_reset = !(primary_reset_n && supervised_reset_n);
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 2'h0;
      watchdog_ok <= 1'h0;
    end
    else if (!primary_reset_n || !trig_en)
    begin
      cnt <= 2'h0;
      watchdog_ok <= 1'h0;
    end
    else if (cnt == 2'h3)
      watchdog_ok <= 1'h1;
    else
      cnt <= cnt + 2'h1;
  end
endmodule

// file: dv/drs_supervisor_tb_top.sv
`timescale 1ns/1ps
module drs_supervisor_tb_top;
  localparam int RC = 50;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  drs_pkg::drs_supply_type sup = 4'hF;
  drs_pkg::drs_fault_type flt = 4'h0;
  logic sw_on = 1'h0;
  logic tick = 1'h0;
  logic wd_fail = 1'h0;
  logic trig_en = 1'h0;
  logic wd_ok, prim, sec, shut, in_rst;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  always #10 core_clk = ~core_clk;
  drs_supervisor #(.RELEASE_CYC(RC)) i_drs_supervisor (
    .core_clk(core_clk), .rst_n(rst_n), .supply(sup), .fault(flt),
    .core_in_switch_on(sw_on), .regulator_tick(tick),
    .watchdog_ok(wd_ok), .watchdog_fail(wd_fail),
    .primary_reset_n(prim), .supervised_reset_n(sec),
    .core_shutdown_req(shut)
  );
  drs_mcu_model i_drs_mcu_model (
    .core_clk(core_clk), .rst_n(rst_n), .primary_reset_n(prim),
    .supervised_reset_n(sec), .trig_en(trig_en),
    .watchdog_ok(wd_ok), .in_reset(in_rst)
  );
  // ----------------------------------
  // Helpers
  // ----------------------------------
  task wrap_up();
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      wrap_up();
    end
  end
  task step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task chk(input string s, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s exp %b got %b", s, e, g);
    end
  endtask
  task rel(input int lo);
    n = 0;
    while (prim !== 1'h1 && n < 300)
    begin
      step(1);
      n++;
    end
    chk("delay", 1'h1, n >= lo && n <= lo + 4);
    step(6);
  endtask
  // ----------------------------------
  // Scenarios
  // ----------------------------------
  task t_powerup();
    step(5);
    rst_n = 1'h1;
    rel(RC);
    chk("prim", 1'h1, prim);
    chk("sec", 1'h0, sec);
    chk("mcu", 1'h1, in_rst);
  endtask
  task t_wd();
    trig_en = 1'h1;
    step(6);
    chk("sec", 1'h1, sec);
    chk("prim", 1'h1, prim);
    trig_en = 1'h0;
    step(3);
    chk("sec", 1'h0, sec);
    chk("prim", 1'h1, prim);
    trig_en = 1'h1;
  endtask
  task t_fault(input int k);
    step(6);
    chk("sec", 1'h1, sec);
    case (k)
      0: flt.core_ov = 1'h1;
      1: flt.peri_ov = 1'h1;
      2: sup.peri_good = 1'h0;
      3: sup.internal_good = 1'h0;
      4: wd_fail = 1'h1;
      default: {sw_on, flt.core_oc} = 2'h3;
    endcase
    step(3);
    chk("prim", 1'h0, prim);
    chk("sec", 1'h0, sec);
    if (k == 0)
      chk("shut", 1'h1, shut);
    {sw_on, wd_fail, flt, sup} = 10'h00F;
    // Delay already runs while a bad trigger is still flagged
    rel(k == 4 ? RC - 2 : RC);
  endtask
  task t_core();
    flt.core_uv = 1'h1;
    repeat (4)
    begin
      tick = 1'h1;
      step(1);
      tick = 1'h0;
      step(1);
    end
    chk("prim", 1'h1, prim);
    tick = 1'h1;
    step(1);
    tick = 1'h0;
    step(3);
    chk("prim", 1'h0, prim);
    flt.core_uv = 1'h0;
    rel(RC);
  endtask
  task t_glitch();
    sup.reserve_good = 1'h0;
    step(400);
    sup.reserve_good = 1'h1;
    step(5);
    chk("prim", 1'h1, prim);
    sup.reserve_good = 1'h0;
    step(510);
    chk("prim", 1'h0, prim);
    sup.reserve_good = 1'h1;
    rel(RC);
  endtask
  task t_restart();
    sup.peri_good = 1'h0;
    step(2);
    sup.peri_good = 1'h1;
    step(30);
    sup.peri_good = 1'h0;
    step(2);
    sup.peri_good = 1'h1;
    rel(RC);
  endtask
  initial
  begin
    t_powerup();
    t_wd();
    for (int k = 0; k < 6; k++)
      t_fault(k);
    t_core();
    t_glitch();
    t_restart();
    wrap_up();
  end
endmodule
